// file: shared/move_unit_pkg.sv
package move_unit_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W = 8;
	localparam int PTR_W = 16;
	localparam int INSTR_W = 14;
	localparam int BANK_W = 5;
	localparam int PAGE_W = 7;
	localparam int FILE_W = 7;
	localparam int OFFS_W = 6;
	localparam int APB_AW = 8;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [APB_AW-1:0] ADDR_INSTR = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_ACC = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_BANK = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_PAGE = 8'h0c;
	localparam logic [APB_AW-1:0] ADDR_PTR0 = 8'h10;
	localparam logic [APB_AW-1:0] ADDR_PTR1 = 8'h14;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h18;
	localparam logic [APB_AW-1:0] ADDR_MEM_ADDR = 8'h1c;
	localparam logic [APB_AW-1:0] ADDR_MEM_DATA = 8'h20;

	// ****************************************
	// Status bit positions and reset values
	// ****************************************
	localparam int STAT_ZERO_BIT = 0;
	localparam int STAT_ILLEGAL_BIT = 1;
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
	localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
	localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
	localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

	// ****************************************
	// Indirect window locations in file space
	// ****************************************
	localparam logic [FILE_W-1:0] WINDOW0_ADDR = 7'h00;
	localparam logic [FILE_W-1:0] WINDOW1_ADDR = 7'h01;

	// ****************************************
	// Pointer update codes
	// ****************************************
	localparam logic [1:0] UPD_PRE_INC = 2'h0;
	localparam logic [1:0] UPD_PRE_DEC = 2'h1;
	localparam logic [1:0] UPD_POST_INC = 2'h2;
	localparam logic [1:0] UPD_POST_DEC = 2'h3;

	// ****************************************
	// Opcode patterns (upper bits of the word)
	// ****************************************
	localparam logic [10:0] OPC_LOAD_IND_UPD = 11'h002;  // bits 13:3
	localparam logic [10:0] OPC_STORE_IND_UPD = 11'h003; // bits 13:3
	localparam logic [6:0] OPC_LOAD_IND_REL = 7'h7e;     // bits 13:7
	localparam logic [6:0] OPC_STORE_IND_REL = 7'h7f;    // bits 13:7
	localparam logic [8:0] OPC_SET_BANK = 9'h001;        // bits 13:5
	localparam logic [6:0] OPC_SET_PAGE = 7'h63;         // bits 13:7
	localparam logic [3:0] OPC_LOAD_LIT = 4'hc;          // bits 13:10
	localparam logic [1:0] LIT_PAD = 2'h0;               // bits 9:8
	localparam logic [6:0] OPC_STORE_FILE = 7'h01;       // bits 13:7

endpackage

// file: shared/ptr_calc_if.sv
interface ptr_calc_if;
	import move_unit_pkg::*;

	logic [PTR_W-1:0] ptr;
	logic relative;
	logic [1:0] update_code;
	logic [OFFS_W-1:0] offset;
	logic [PTR_W-1:0] eff_addr;
	logic [PTR_W-1:0] new_ptr;

	// Decoder drives the request, calculator answers
	modport decoder (output ptr, relative, update_code, offset, input eff_addr, new_ptr);
	modport calc (input ptr, relative, update_code, offset, output eff_addr, new_ptr);
endinterface

// file: src/ptr_calc.sv
module ptr_calc
	import move_unit_pkg::*;
(
	// Pointer arithmetic
	ptr_calc_if.calc pc
);

	logic [PTR_W-1:0] sext_offset;
	logic [PTR_W-1:0] plus_one;
	logic [PTR_W-1:0] minus_one;

	// Sixteen-bit sums drop the carry, so both bounds wrap
	assign sext_offset = {{(PTR_W-OFFS_W){pc.offset[OFFS_W-1]}}, pc.offset};
	assign plus_one = pc.ptr + 16'h0001;
	assign minus_one = pc.ptr - 16'h0001;

	// Effective address and pointer value after the move
	always_comb begin
		if (pc.relative) begin
			pc.eff_addr = pc.ptr + sext_offset;
			pc.new_ptr = pc.ptr;
		end else begin
			case (pc.update_code)
				UPD_PRE_INC: begin
					pc.eff_addr = plus_one;
					pc.new_ptr = plus_one;
				end
				UPD_PRE_DEC: begin
					pc.eff_addr = minus_one;
					pc.new_ptr = minus_one;
				end
				UPD_POST_INC: begin
					pc.eff_addr = pc.ptr;
					pc.new_ptr = plus_one;
				end
				default: begin
					pc.eff_addr = pc.ptr;
					pc.new_ptr = minus_one;
				end
			endcase
		end
	end

endmodule

// file: src/move_unit.sv
// Function
// - Load-indirect copies addressed byte into accumulator and updates the zero flag.
// - Effective address is pointer+1 (pre-inc), pointer-1 (pre-dec), pointer itself (post-inc, post-dec), or pointer plus signed offset -32..31.
// - Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Pointer afterwards is +1 for increments, -1 for decrements, unchanged if relative.
// - Pointers are sixteen bits and wrap at both ends.
// - Store-file to a window location goes to the address the pointer holds; indirect and software accesses use bytes 0 and 1 as plain storage.
// - Pointer increment or decrement leaves every status flag alone.
// - Store-indirect writes accumulator through same addressing, flags untouched.
// - Set-bank loads five-bit literal into bank select, flags untouched.
// - Set-page-latch loads seven-bit literal into upper program latch, flags untouched.
// - Load-literal puts eight-bit literal in accumulator in one cycle, flags untouched.
// - Unused operand bits of load-literal must be zero in the word.
// - Store-file copies accumulator to seven-bit file address in one cycle, no flags.
module move_unit
	import move_unit_pkg::*;
#(
	parameter int MEM_AW = 7
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Core state
	output logic [DATA_W-1:0] ACC_OUT,
	output logic ZERO_OUT
);

	localparam int MEM_DEPTH = 1 << MEM_AW;

	// ****************************************
	// State
	// ****************************************
	logic [DATA_W-1:0] acc_ff;
	logic zero_ff;
	logic illegal_ff;
	logic [BANK_W-1:0] bank_select_ff;
	logic [PAGE_W-1:0] upper_program_latch_ff;
	logic [PTR_W-1:0] ptr0_ff;
	logic [PTR_W-1:0] ptr1_ff;
	logic [INSTR_W-1:0] instr_ff;
	logic [MEM_AW-1:0] mem_addr_ff;
	logic [DATA_W-1:0] mem_ff [MEM_DEPTH];
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;

	// ****************************************
	// APB handshake
	// ****************************************
	logic access;
	logic done;
	logic wr_done;
	logic mapped;

	// Answer one cycle into the access phase so outputs stay registered
	assign access = PSEL & PENABLE;
	assign done = access & pready_ff;
	assign wr_done = done & PWRITE;

	// Address decode
	always_comb begin
		case (PADDR)
			ADDR_INSTR, ADDR_ACC, ADDR_BANK, ADDR_PAGE, ADDR_PTR0, ADDR_PTR1,
			ADDR_STATUS, ADDR_MEM_ADDR, ADDR_MEM_DATA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Ready pulses for one cycle per access
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= access & ~pready_ff;
			pslverr_ff <= access & ~pready_ff & ~mapped;
		end
	end

	// ****************************************
	// Instruction decode
	// ****************************************
	logic [INSTR_W-1:0] w;
	logic exec;
	logic is_load_upd, is_store_upd, is_load_rel, is_store_rel;
	logic is_load_ind, is_store_ind, is_indirect;
	logic is_set_bank, is_set_page, is_load_lit, is_store_file, is_illegal;
	logic sel_ptr1;

	assign w = PWDATA[INSTR_W-1:0];
	assign exec = wr_done & (PADDR == ADDR_INSTR);

	// Fixed opcode fields pick the instruction
	assign is_load_upd = (w[13:3] == OPC_LOAD_IND_UPD);
	assign is_store_upd = (w[13:3] == OPC_STORE_IND_UPD);
	assign is_load_rel = (w[13:7] == OPC_LOAD_IND_REL);
	assign is_store_rel = (w[13:7] == OPC_STORE_IND_REL);
	assign is_set_bank = (w[13:5] == OPC_SET_BANK);
	assign is_set_page = (w[13:7] == OPC_SET_PAGE);
	assign is_load_lit = (w[13:10] == OPC_LOAD_LIT) & (w[9:8] == LIT_PAD);
	assign is_store_file = (w[13:7] == OPC_STORE_FILE);
	assign is_load_ind = is_load_upd | is_load_rel;
	assign is_store_ind = is_store_upd | is_store_rel;
	assign is_indirect = is_load_ind | is_store_ind;
	// A literal load with nonzero pad bits falls here and sets the decode error, except pad 01 with literal bit 7 set, which decodes as set-page
	assign is_illegal = ~(is_indirect | is_set_bank | is_set_page | is_load_lit | is_store_file);
	assign sel_ptr1 = (is_load_rel | is_store_rel) ? w[6] : w[2];

	// ****************************************
	// Pointer arithmetic
	// ****************************************
	ptr_calc_if pcif ();

	assign pcif.ptr = sel_ptr1 ? ptr1_ff : ptr0_ff;
	assign pcif.relative = is_load_rel | is_store_rel;
	assign pcif.update_code = w[1:0];
	assign pcif.offset = w[OFFS_W-1:0];

	ptr_calc u_ptr_calc (
		.pc(pcif.calc)
	);

	// ****************************************
	// Memory access paths
	// ****************************************
	logic [MEM_AW-1:0] ind_idx;
	logic [DATA_W-1:0] ind_data;
	logic [FILE_W-1:0] file_addr;
	logic [MEM_AW-1:0] file_idx;
	logic mem_we;
	logic [MEM_AW-1:0] mem_widx;
	logic [DATA_W-1:0] mem_wdata;

	assign ind_idx = pcif.eff_addr[MEM_AW-1:0];
	assign ind_data = mem_ff[ind_idx];
	assign file_addr = w[FILE_W-1:0];

	// Window addresses own no storage; use the pointer's target instead
	always_comb begin
		if (file_addr == WINDOW0_ADDR) begin
			file_idx = ptr0_ff[MEM_AW-1:0];
		end else if (file_addr == WINDOW1_ADDR) begin
			file_idx = ptr1_ff[MEM_AW-1:0];
		end else begin
			file_idx = MEM_AW'(file_addr);
		end
	end

	// One write port: instruction stores first, then software writes
	always_comb begin
		mem_we = 1'b0;
		mem_widx = mem_addr_ff;
		mem_wdata = PWDATA[DATA_W-1:0];
		if (exec & is_store_ind) begin
			mem_we = 1'b1;
			mem_widx = ind_idx;
			mem_wdata = acc_ff;
		end else if (exec & is_store_file) begin
			mem_we = 1'b1;
			mem_widx = file_idx;
			mem_wdata = acc_ff;
		end else if (wr_done & (PADDR == ADDR_MEM_DATA)) begin
			mem_we = 1'b1;
		end
	end

	// ****************************************
	// File storage
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
			// Each entry is a plain byte register
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					mem_ff[gi] <= 8'h00;
				end else if (mem_we && (mem_widx == MEM_AW'(gi))) begin
					mem_ff[gi] <= mem_wdata;
				end
			end
		end
	endgenerate

	// ****************************************
	// Accumulator and flags
	// ****************************************
	// Literal and indirect loads land in one cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			acc_ff <= ACC_RST;
		end else if (exec & is_load_ind) begin
			acc_ff <= ind_data;
		end else if (exec & is_load_lit) begin
			acc_ff <= w[DATA_W-1:0];
		end else if (wr_done & (PADDR == ADDR_ACC)) begin
			acc_ff <= PWDATA[DATA_W-1:0];
		end
	end

	// Only the indirect load touches the zero flag; pointer steps never do
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			zero_ff <= 1'b0;
		end else if (exec & is_load_ind) begin
			zero_ff <= (ind_data == 8'h00);
		end
	end

	// Sticky decode error; a new bad word wins over a same-cycle clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			illegal_ff <= 1'b0;
		end else if (exec & is_illegal) begin
			illegal_ff <= 1'b1;
		end else if (wr_done & (PADDR == ADDR_STATUS) & PWDATA[STAT_ILLEGAL_BIT]) begin
			illegal_ff <= 1'b0;
		end
	end

	// ****************************************
	// Bank select and upper program latch
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bank_select_ff <= BANK_RST;
		end else if (exec & is_set_bank) begin
			bank_select_ff <= w[BANK_W-1:0];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			upper_program_latch_ff <= PAGE_RST;
		end else if (exec & is_set_page) begin
			upper_program_latch_ff <= w[PAGE_W-1:0];
		end
	end

	// ****************************************
	// Indirect pointers
	// ****************************************
	// Pointer step happens in the same cycle as the move
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ptr0_ff <= PTR_RST;
		end else if (exec & is_indirect & ~sel_ptr1) begin
			ptr0_ff <= pcif.new_ptr;
		end else if (wr_done & (PADDR == ADDR_PTR0)) begin
			ptr0_ff <= PWDATA[PTR_W-1:0];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ptr1_ff <= PTR_RST;
		end else if (exec & is_indirect & sel_ptr1) begin
			ptr1_ff <= pcif.new_ptr;
		end else if (wr_done & (PADDR == ADDR_PTR1)) begin
			ptr1_ff <= PWDATA[PTR_W-1:0];
		end
	end

	// ****************************************
	// Software-visible helpers
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			instr_ff <= INSTR_RST;
		end else if (exec) begin
			instr_ff <= w;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mem_addr_ff <= '0;
		end else if (wr_done & (PADDR == ADDR_MEM_ADDR)) begin
			mem_addr_ff <= PWDATA[MEM_AW-1:0];
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	logic [31:0] rd_mux;

	// Unused upper bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (PADDR)
			ADDR_INSTR: rd_mux[INSTR_W-1:0] = instr_ff;
			ADDR_ACC: rd_mux[DATA_W-1:0] = acc_ff;
			ADDR_BANK: rd_mux[BANK_W-1:0] = bank_select_ff;
			ADDR_PAGE: rd_mux[PAGE_W-1:0] = upper_program_latch_ff;
			ADDR_PTR0: rd_mux[PTR_W-1:0] = ptr0_ff;
			ADDR_PTR1: rd_mux[PTR_W-1:0] = ptr1_ff;
			ADDR_STATUS: begin
				rd_mux[STAT_ZERO_BIT] = zero_ff;
				rd_mux[STAT_ILLEGAL_BIT] = illegal_ff;
			end
			ADDR_MEM_ADDR: rd_mux[MEM_AW-1:0] = mem_addr_ff;
			ADDR_MEM_DATA: rd_mux[DATA_W-1:0] = mem_ff[mem_addr_ff];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Captured one edge before ready is seen, held until the next read
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			prdata_ff <= 32'h0000_0000;
		end else if (access & ~pready_ff & ~PWRITE) begin
			prdata_ff <= rd_mux;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign PRDATA = prdata_ff;
	assign PREADY = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign ACC_OUT = acc_ff;
	assign ZERO_OUT = zero_ff;

endmodule

// file: verification/move_unit_asserts.sv
module move_unit_asserts
	import move_unit_pkg::*;
#(
	parameter int MEM_AW = 7
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Core state
	input wire logic [DATA_W-1:0] ACC_OUT,
	input wire logic ZERO_OUT
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// ****************************************
	// Decode of the committing transfer
	// ****************************************
	logic xfer, wr_ins, wr_acc, is_li, lit_ok, lit_bad;

	// Only the edge with PREADY high commits, so all decode keys on it
	assign xfer = PSEL && PENABLE && PREADY;
	assign wr_ins = xfer && PWRITE && PADDR == ADDR_INSTR;
	assign wr_acc = xfer && PWRITE && PADDR == ADDR_ACC;
	assign is_li = PWDATA[13:3] == OPC_LOAD_IND_UPD || PWDATA[13:7] == OPC_LOAD_IND_REL;
	assign lit_ok = PWDATA[13:10] == OPC_LOAD_LIT && PWDATA[9:8] == LIT_PAD;
	assign lit_bad = PWDATA[13:10] == OPC_LOAD_LIT && PWDATA[9:8] != LIT_PAD;

	// ****************************************
	// Properties
	// ****************************************
	AST_LIT_ACC: assert property (wr_ins && lit_ok |=> ACC_OUT == $past(PWDATA[7:0]))
		else $error("literal load did not reach the accumulator");
	AST_LOAD_ZERO: assert property (wr_ins && is_li |=> ZERO_OUT == (ACC_OUT == 8'h00))
		else $error("zero flag does not match the loaded byte");
	AST_ZERO_KEEP: assert property (!(wr_ins && is_li) |=> $stable(ZERO_OUT))
		else $error("zero flag moved without an indirect load");
	AST_ACC_KEEP: assert property (!(wr_acc || wr_ins && (is_li || lit_ok)) |=> $stable(ACC_OUT))
		else $error("accumulator moved without a loading cause");
	AST_PAD_REFUSE: assert property (wr_ins && lit_bad |=> $stable(ACC_OUT) [*2])
		else $error("literal with nonzero pad bits changed the accumulator");
	AST_RDY_DELAY: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready did not follow the first access cycle");
	AST_RDY_PULSE: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	AST_ERR_MAP: assert property (xfer && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > ADDR_MEM_DATA))
		else $error("slave error does not match the address map");

	// Main scenarios reached
	cover property (wr_ins && is_li && PWDATA[1:0] == UPD_POST_DEC);
	cover property (wr_ins && lit_bad);
	cover property (xfer && PSLVERR);
endmodule

// file: verification/move_unit_tb.sv
module move_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import move_unit_pkg::*;

	logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ZERO_OUT;
	logic [7:0] PADDR, ACC_OUT, m_acc, lit, mem[128];
	logic [31:0] PWDATA, PRDATA, r;
	logic [15:0] m_ptr[2], a, v;
	logic [13:0] ins;
	logic [6:0] m_page, ma, f;
	logic [5:0] o;
	logic [4:0] m_bank;
	logic [1:0] c, pad;
	logic m_z, m_ill, sel, rel;
	int miscompares, n_tests, k;
	logic [7:0] k2[7] = '{ADDR_INSTR, ADDR_ACC, ADDR_BANK, ADDR_PAGE, ADDR_PTR0, ADDR_PTR1,
		ADDR_STATUS};

	move_unit #(.MEM_AW(7)) move_unit_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .ACC_OUT(ACC_OUT), .ZERO_OUT(ZERO_OUT));

	// Free-running 125 MHz clock
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// ****************************************
	// Reporting and bus tasks
	// ****************************************
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until PREADY is sampled high; one idle edge after avoids double drives
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rd_v);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= ad;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			give_verdict();
		end
		rd_v = PRDATA;
		chk("slverr", {31'h0, PSLVERR}, {31'h0, ad > ADDR_MEM_DATA});
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask

	task wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] dummy;
		apb(1'b1, ad, d, dummy);
	endtask

	task rdc(input string what, input logic [7:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0, r);
		chk(what, r, exp);
	endtask

	// ****************************************
	// Expected pointer arithmetic
	// ****************************************
	function automatic logic [15:0] eff(logic [15:0] p, logic rl, logic [1:0] cd, logic [5:0] of);
		if (rl) return p + {{10{of[5]}}, of};
		if (cd == UPD_PRE_INC) return p + 16'h1;
		if (cd == UPD_PRE_DEC) return p - 16'h1;
		return p;
	endfunction

	function automatic logic [15:0] nxt(logic [15:0] p, logic rl, logic [1:0] cd);
		if (rl) return p;
		return cd[0] ? p - 16'h1 : p + 16'h1;
	endfunction

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		RST = 1'b1;
		{m_acc, m_z, m_ill, m_bank, m_page, miscompares, n_tests} = '0;
		m_ptr = '{16'h0, 16'h0};
		void'($urandom(32'he5086c4c));
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		// Reset values, the read-only bank register and an unmapped word
		foreach (k2[j]) rdc("reset", k2[j], 32'h0);
		wr(ADDR_BANK, 32'h1f);
		rdc("bank_ro", ADDR_BANK, 32'h0);
		rdc("unmapped", 8'h24, 32'h0);
		// Preload storage, with plenty of zero bytes
		for (int j = 0; j < 128; j++) begin
			mem[j] = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
			wr(ADDR_MEM_ADDR, j);
			wr(ADDR_MEM_DATA, {24'h0, mem[j]});
		end
		for (int i = 0; i < 400; i++) begin
			k = (i < 8) ? i : $urandom % 8;
			sel = 1'($urandom);
			c = 2'($urandom);
			o = 6'($urandom);
			lit = 8'($urandom);
			pad = ($urandom % 5 == 0) ? 2'($urandom) : 2'h0;
			if ($urandom % 3 == 0) begin
				v = ($urandom % 2) ? 16'hffff * 16'($urandom % 2) : 16'($urandom);
				wr(sel ? ADDR_PTR1 : ADDR_PTR0, {16'h0, v});
				m_ptr[sel] = v;
			end
			if (i % 5 == 0) begin
				m_acc = (i % 10 == 0) ? 8'h00 : lit;
				wr(ADDR_ACC, {24'h0, m_acc});
			end
			if (k < 4) begin
				rel = k[1];
				ins = rel ? {k[0] ? OPC_STORE_IND_REL : OPC_LOAD_IND_REL, sel, o}
					: {k[0] ? OPC_STORE_IND_UPD : OPC_LOAD_IND_UPD, sel, c};
				a = eff(m_ptr[sel], rel, c, o);
				ma = a[6:0];
				if (k[0]) mem[ma] = m_acc;
				else {m_acc, m_z} = {mem[ma], mem[ma] == 8'h00};
				m_ptr[sel] = nxt(m_ptr[sel], rel, c);
			end else if (k == 4) begin
				ins = {OPC_SET_BANK, lit[4:0]};
				m_bank = lit[4:0];
			end else if (k == 5) begin
				ins = {OPC_SET_PAGE, lit[6:0]};
				m_page = lit[6:0];
			end else if (k == 6) begin
				ins = {OPC_LOAD_LIT, pad, lit};
				// Pad 01 with a set top literal bit spells the set-page word instead
				if (pad == LIT_PAD) m_acc = lit;
				else if ({OPC_LOAD_LIT, pad, lit[7]} == OPC_SET_PAGE) m_page = lit[6:0];
				else m_ill = 1'b1;
			end else begin
				// Window addresses redirect through the pointers
				f = ($urandom % 2) ? {6'h0, sel} : lit[6:0];
				ins = {OPC_STORE_FILE, f};
				ma = (f == WINDOW0_ADDR) ? m_ptr[0][6:0] : (f == WINDOW1_ADDR) ? m_ptr[1][6:0] : f;
				mem[ma] = m_acc;
			end
			wr(ADDR_INSTR, {18'h0, ins});
			chk("acc", {24'h0, ACC_OUT}, {24'h0, m_acc});
			chk("zero", {31'h0, ZERO_OUT}, {31'h0, m_z});
			rdc("bank", ADDR_BANK, {27'h0, m_bank});
			rdc("page", ADDR_PAGE, {25'h0, m_page});
			rdc("ptr0", ADDR_PTR0, {16'h0, m_ptr[0]});
			rdc("ptr1", ADDR_PTR1, {16'h0, m_ptr[1]});
			rdc("status", ADDR_STATUS, {30'h0, m_ill, m_z});
			if (m_ill) begin
				wr(ADDR_STATUS, 32'h2);
				m_ill = 1'b0;
			end
			if (k[0] && k < 4 || k == 7) begin
				wr(ADDR_MEM_ADDR, {25'h0, ma});
				rdc("store", ADDR_MEM_DATA, {24'h0, mem[ma]});
			end
		end
		give_verdict();
	end
endmodule

bind move_unit move_unit_asserts #(.MEM_AW(MEM_AW)) move_unit_asserts_i (.CLK(CLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ACC_OUT(ACC_OUT), .ZERO_OUT(ZERO_OUT));
